// >>> pkg/tcc_pkg.sv
// Package for the timer counter core: register map, field layout, codes.
// Assumes a 32-bit classic Wishbone slave with byte-wide registers in the low lanes.
package tcc_pkg;

  // ---------------------------------------------------------------
  // Register word offsets (byte addresses).
  // ---------------------------------------------------------------
  localparam logic [7:0] TCC_OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] TCC_OFS_COUNTER_HIGH = 8'h04;
  localparam logic [7:0] TCC_OFS_COUNTER_LOW = 8'h08;
  localparam logic [7:0] TCC_OFS_MODULO = 8'h0c;
  localparam logic [7:0] TCC_OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] TCC_OFS_IRQ_MASK = 8'h14;

  // ---------------------------------------------------------------
  // Field positions of the status and control register and the interrupt status register.
  // ---------------------------------------------------------------
  localparam int TCC_BIT_OVERFLOW = 7;
  localparam int TCC_BIT_IRQ_ENABLE = 6;
  localparam int TCC_BIT_CENTER = 5;
  localparam int TCC_BIT_EVT_OVERFLOW = 0;

  // Reset values and limits.
  localparam logic [15:0] TCC_COUNT_RESET = 16'h0000;
  localparam logic [15:0] TCC_MODULO_RESET = 16'h0000;
  localparam logic [15:0] TCC_COUNT_FULL = 16'hffff;
  localparam logic [6:0] TCC_PRESCALE_FULL = 7'h7f;
  localparam logic [2:0] TCC_PRESCALE_MAX = 3'h7;
  localparam logic [7:0] TCC_EVT_RESET = 8'h00;

  // Clock source codes.
  typedef enum logic [1:0] {
    TCC_SRC_NONE = 2'h0,
    TCC_SRC_BUS = 2'h1,
    TCC_SRC_FIXED = 2'h2,
    TCC_SRC_EXTERNAL = 2'h3
  } tcc_src_e;

  // Counting direction.
  typedef enum logic {
    TCC_DIR_UP,
    TCC_DIR_DOWN
  } tcc_dir_e;

  // Status and control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic overflow_flag;
    logic overflow_irq_enable;
    logic center_pwm_select;
    tcc_src_e clock_source_select;
    logic [2:0] prescale_select;
  } tcc_sc_s;

  localparam tcc_sc_s TCC_SC_RESET = '{1'b0, 1'b0, 1'b0, TCC_SRC_NONE, 3'h0};

  // Counter read buffer state.
  typedef struct packed {
    logic held;
    logic [15:0] value;
  } tcc_latch_s;

endpackage : tcc_pkg

// >>> rtl/tcc_core.sv
// Timer counter core: status and control, prescaler, 16-bit counter, read buffer.
// Assumes one 100 MHz bus clock, a classic Wishbone master, a fixed-clock tick
// already in this domain, a debug halt level from same-clock logic, and an
// asynchronous external clock pin.
//
// Overview of operation
// - Wrap to zero past modulo sets overflow flag.
// - Flag clears by read-while-set then write zero.
// - Overflow between read and write restarts clearing.
// - Writing one keeps flag; reset clears it.
// - Interrupt while flag and enable both set.
// - Center select: up-down counting, all channels center.
// - Source field: none, bus, fixed, external.
// - External source synchronized here; fixed arrives synchronized.
// - Prescale divides by two to the code.
// - Prescaler after selection; new factor next cycle.
// - Reading either byte latches both until other read.
// - Reset or control write restarts read latch.
// - Reset or counter write clears counter and latch.
// - Debug halt freezes counter; reads give frozen value.
// - Debug halt keeps read latch state unchanged.
// - Writes during halt still restart read latch.
// - In up mode, after modulo, counter resumes from zero next tick; center mode counts down.
// - Modulo zero means free-running full range.
//
// Chosen here: the Wishbone slave port and the placing of the registers.
module tcc_core
  import tcc_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_WIDTH-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ext_clk_i,
  input wire logic fixed_tick_i,
  input wire logic debug_halt_i,
  output logic counting_down_o,
  output logic center_pwm_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Bus decode.
  // ---------------------------------------------------------------

  // A request is taken once, in the cycle before the acknowledge goes out.
  logic take;
  logic wr;
  logic rd;
  logic [7:0] ofs;
  logic sel_sc;
  logic sel_hi;
  logic sel_lo;
  logic sel_mod;
  logic sel_ist;
  logic sel_imk;

  assign take = cyc_i & stb_i & ~ack_o;
  assign wr = take & we_i;
  assign rd = take & ~we_i;
  assign ofs = adr_i[7:0];
  assign sel_sc = (ofs == TCC_OFS_STATUS_CONTROL);
  assign sel_hi = (ofs == TCC_OFS_COUNTER_HIGH);
  assign sel_lo = (ofs == TCC_OFS_COUNTER_LOW);
  assign sel_mod = (ofs == TCC_OFS_MODULO);
  assign sel_ist = (ofs == TCC_OFS_IRQ_STATUS);
  assign sel_imk = (ofs == TCC_OFS_IRQ_MASK);

  // Byte-lane qualified writes; the byte registers live in lane 0.
  logic wr_sc;
  logic wr_cnt;
  assign wr_sc = wr & sel_sc & sel_i[0];
  assign wr_cnt = wr & (sel_hi | sel_lo) & sel_i[0];

  // ---------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------
  tcc_sc_s sc_q;
  logic [15:0] count_q;
  logic [15:0] modulo_q;
  tcc_dir_e dir_q;
  logic [6:0] pre_q;
  logic clear_armed_q;
  tcc_latch_s latch_q;
  logic [7:0] evt_q;
  logic [7:0] evt_mask_q;
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;

  // ---------------------------------------------------------------
  // Clock source selection and prescaler.
  // ---------------------------------------------------------------

  // Two flops bring the external pin into the bus domain; a third
  // remembers the last level so a rising edge becomes one tick.
  // The pin must run at no more than a quarter of the bus rate.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_clk_i;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  // Source tick per the select field; none means no tick at all.
  logic src_tick;
  always_comb begin
    unique case (sc_q.clock_source_select)
      TCC_SRC_NONE: src_tick = 1'b0;
      TCC_SRC_BUS: src_tick = 1'b1;
      TCC_SRC_FIXED: src_tick = fixed_tick_i;
      TCC_SRC_EXTERNAL: src_tick = ext_sync_q & ~ext_prev_q;
    endcase
  end

  // The prescaler sees the selected, synchronized tick, and the mask is
  // read live from the register so a new factor acts one cycle after the
  // write lands.
  logic [6:0] pre_mask;
  logic cnt_tick;
  logic halted;
  assign halted = debug_halt_i;
  assign pre_mask = TCC_PRESCALE_FULL >> (TCC_PRESCALE_MAX - sc_q.prescale_select);
  assign cnt_tick = src_tick & ~halted & ((pre_q & pre_mask) == pre_mask);

  always_ff @(posedge clk_i) begin
    if (rst_i || wr_cnt) begin
      pre_q <= '0;
    end else if (src_tick && !halted) begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // ---------------------------------------------------------------
  // Counter.
  // ---------------------------------------------------------------

  // Modulo zero is treated as the full range.
  logic [15:0] top;
  logic at_top;
  logic wrap_evt;
  assign top = (modulo_q == TCC_MODULO_RESET) ? TCC_COUNT_FULL : modulo_q;
  assign at_top = (count_q == top);

  // Overflow: in up mode the wrap to zero; in up-down mode the return to
  // zero at the bottom of the triangle, which ends one full period.
  always_comb begin
    if (!cnt_tick) begin
      wrap_evt = 1'b0;
    end else if (sc_q.center_pwm_select) begin
      wrap_evt = (dir_q == TCC_DIR_DOWN) && (count_q == (TCC_COUNT_RESET + 16'h0001));
    end else begin
      wrap_evt = at_top;
    end
  end

  // Debug halt simply withholds the tick, which freezes the count.
  always_ff @(posedge clk_i) begin
    if (rst_i || wr_cnt) begin
      count_q <= TCC_COUNT_RESET;
      dir_q <= TCC_DIR_UP;
    end else if (cnt_tick) begin
      if (!sc_q.center_pwm_select) begin
        dir_q <= TCC_DIR_UP;
        count_q <= at_top ? TCC_COUNT_RESET : count_q + 16'h0001;
      end else if (dir_q == TCC_DIR_UP) begin
        if (at_top) begin
          dir_q <= TCC_DIR_DOWN;
          count_q <= count_q - 16'h0001;
        end else begin
          count_q <= count_q + 16'h0001;
        end
      end else begin
        if (count_q == TCC_COUNT_RESET) begin
          dir_q <= TCC_DIR_UP;
          count_q <= count_q + 16'h0001;
        end else begin
          count_q <= count_q - 16'h0001;
        end
      end
    end else if (!sc_q.center_pwm_select) begin
      dir_q <= TCC_DIR_UP;
    end
  end

  // Modulo holds a plain 16-bit value; lanes 0 and 1, when enabled, write straight into it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      modulo_q <= TCC_MODULO_RESET;
    end else if (wr && sel_mod) begin
      if (sel_i[0]) begin
        modulo_q[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        modulo_q[15:8] <= dat_i[15:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // Status and control register.
  // ---------------------------------------------------------------

  // Control fields load from any write; the flag sits in the same process so
  // the register has one driver. A set wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sc_q <= TCC_SC_RESET;
    end else begin
      if (wr_sc) begin
        sc_q.overflow_irq_enable <= dat_i[TCC_BIT_IRQ_ENABLE];
        sc_q.center_pwm_select <= dat_i[TCC_BIT_CENTER];
        sc_q.clock_source_select <= tcc_src_e'(dat_i[4:3]);
        sc_q.prescale_select <= dat_i[2:0];
      end
      if (wrap_evt) begin
        sc_q.overflow_flag <= 1'b1;
      end else if (wr_sc && clear_armed_q && !dat_i[TCC_BIT_OVERFLOW]) begin
        sc_q.overflow_flag <= 1'b0;
      end
    end
  end

  // Clearing needs a read that saw the flag set, then a zero write. A
  // fresh overflow disarms the sequence, so the flag survives.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clear_armed_q <= 1'b0;
    end else if (wrap_evt) begin
      clear_armed_q <= 1'b0;
    end else if (rd && sel_sc && sc_q.overflow_flag) begin
      clear_armed_q <= 1'b1;
    end else if (wr_sc) begin
      clear_armed_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Coherent counter read buffer.
  // ---------------------------------------------------------------

  // The first byte read freezes both bytes; reading the other releases.
  // Which byte was first is kept so a repeat of the same byte does not
  // release the buffer early. Halt leaves the buffer untouched, but
  // writes still restart it.
  logic first_hi_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_q <= '0;
      first_hi_q <= 1'b0;
    end else if (wr_sc || wr_cnt) begin
      latch_q.held <= 1'b0;
    end else if (rd && (sel_hi || sel_lo) && !halted) begin
      if (!latch_q.held) begin
        latch_q.held <= 1'b1;
        latch_q.value <= count_q;
        first_hi_q <= sel_hi;
      end else if (sel_hi != first_hi_q) begin
        latch_q.held <= 1'b0;
      end
    end
  end

  // A read returns the buffer while it holds, else the live (or frozen) count.
  logic [15:0] read_count;
  assign read_count = latch_q.held ? latch_q.value : count_q;

  // ---------------------------------------------------------------
  // Interrupt status and mask.
  // ---------------------------------------------------------------

  // Overflow also sets a sticky event bit, cleared by writing a one; a new
  // event in the clearing cycle wins.
  logic [7:0] evt_set;
  always_comb begin
    evt_set = '0;
    evt_set[TCC_BIT_EVT_OVERFLOW] = wrap_evt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_q <= TCC_EVT_RESET;
    end else if (wr && sel_ist && sel_i[0]) begin
      evt_q <= (evt_q & ~dat_i[7:0]) | evt_set;
    end else begin
      evt_q <= evt_q | evt_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_mask_q <= TCC_EVT_RESET;
    end else if (wr && sel_imk && sel_i[0]) begin
      evt_mask_q <= dat_i[7:0];
    end
  end

  // The line follows the documented flag-and-enable pair or any unmasked
  // sticky bit; it is registered, so it trails its cause by one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (sc_q.overflow_flag & sc_q.overflow_irq_enable) | (|(evt_q & evt_mask_q));
    end
  end

  // ---------------------------------------------------------------
  // Bus answer and mode outputs.
  // ---------------------------------------------------------------

  // Every access, mapped or not, is acknowledged one cycle after it is
  // presented; unmapped reads give zero and unmapped writes are dropped.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= take;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (rd) begin
      dat_o <= '0;
      if (sel_sc) begin
        dat_o[7:0] <= sc_q;
      end else if (sel_hi) begin
        dat_o[7:0] <= read_count[15:8];
      end else if (sel_lo) begin
        dat_o[7:0] <= read_count[7:0];
      end else if (sel_mod) begin
        dat_o[15:0] <= modulo_q;
      end else if (sel_ist) begin
        dat_o[7:0] <= evt_q;
      end else if (sel_imk) begin
        dat_o[7:0] <= evt_mask_q;
      end
    end
  end

  // Mode lines for the channel logic that sits beside this core.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      center_pwm_o <= 1'b0;
      counting_down_o <= 1'b0;
    end else begin
      center_pwm_o <= sc_q.center_pwm_select;
      counting_down_o <= (dir_q == TCC_DIR_DOWN);
    end
  end

endmodule : tcc_core

// >>> sim/tcc_core_props.sv
// Checker for the timer counter core: bus answer, mode outputs, interrupt, halt.
// Assumes the bench's classic Wishbone master and byte-wide registers.
module tcc_core_chk
  import tcc_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_WIDTH-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic ext_clk_i,
  input wire logic fixed_tick_i,
  input wire logic debug_halt_i,
  input wire logic counting_down_o,
  input wire logic center_pwm_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // -------------------------------------------------------------
  // Helper logic
  // -------------------------------------------------------------
  logic take, rd_ack, lo_halt, wr_sc, hv_q, c_q;
  logic [7:0] hlo_q;
  // Request decode as seen on the bus.
  assign take = cyc_i && stb_i && !ack_o;
  assign rd_ack = ack_o && !we_i;
  assign lo_halt = rd_ack && debug_halt_i && adr_i == TCC_OFS_COUNTER_LOW;
  assign wr_sc = take && we_i && adr_i == TCC_OFS_STATUS_CONTROL && sel_i[0];
  // A write may clear the count, so it forgets the remembered halt value.
  always_ff @(posedge clk_i) begin
    if (rst_i || !debug_halt_i || (take && we_i)) begin
      hv_q <= 1'b0;
    end else if (lo_halt) begin
      hv_q <= 1'b1;
    end
  end
  // Low byte seen in halt and the center select last written.
  always_ff @(posedge clk_i) begin
    if (lo_halt) begin
      hlo_q <= dat_o[7:0];
    end
    if (wr_sc) begin
      c_q <= dat_i[TCC_BIT_CENTER];
    end
  end
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  AST_ACK_NEXT: assert property (take |=> ack_o)
    else $error("ack missing after take");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_RST_QUIET: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o && !center_pwm_o)
    else $error("outputs active after reset");
  AST_CENTER_COPY: assert property (wr_sc |-> ##2 center_pwm_o == c_q)
    else $error("center output not following write");
  AST_UP_ONLY: assert property (!center_pwm_o [*3] |-> !counting_down_o)
    else $error("down count outside center mode");
  AST_IRQ_FLAG: assert property (rd_ack && adr_i == TCC_OFS_STATUS_CONTROL
    && dat_o[7:6] == 2'b11 |-> irq_o)
    else $error("flag and enable set without irq");
  AST_HALT_FREEZE: assert property (lo_halt && hv_q |-> dat_o[7:0] == hlo_q)
    else $error("counter moved during halt");
  AST_BYTE_READ: assert property (rd_ack && (adr_i == TCC_OFS_COUNTER_HIGH
    || adr_i == TCC_OFS_COUNTER_LOW) |-> dat_o[31:8] == 24'h000000)
    else $error("counter byte read wider than a byte");
  COV_CNT_WRITE: cover property (take && we_i && adr_i == TCC_OFS_COUNTER_LOW);
  COV_HALT_READ: cover property (lo_halt && hv_q);
  COV_IRQ_READ: cover property (rd_ack && irq_o && adr_i == TCC_OFS_STATUS_CONTROL);
endmodule // tcc_core_chk

bind tcc_core tcc_core_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .ext_clk_i(ext_clk_i), .fixed_tick_i(fixed_tick_i), .debug_halt_i(debug_halt_i),
  .counting_down_o(counting_down_o), .center_pwm_o(center_pwm_o), .irq_o(irq_o));

// >>> sim/tcc_core_tb.sv
// Self-checking bench for the timer counter core over classic Wishbone.
// Assumes an ack one cycle after each take and the checker bound to the core.
module tcc_core_tb
  import tcc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SC = TCC_OFS_STATUS_CONTROL;
  localparam logic [7:0] CH = TCC_OFS_COUNTER_HIGH;
  localparam logic [7:0] CL = TCC_OFS_COUNTER_LOW;
  localparam logic [7:0] MD = TCC_OFS_MODULO;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, me, mm, ms, ex;
  logic ack_o, counting_down_o, center_pwm_o, irq_o;
  logic ext_clk_i = 1'b0, fixed_tick_i = 1'b0, debug_halt_i = 1'b0;
  logic [31:0] eq[$], mq[$];
  int tq[$];
  int n_mismatch = 0, total_checks = 0, mt, sh;
  integer seed = 32'he499;

  tcc_core #(.ADDR_WIDTH(8)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_clk_i(ext_clk_i), .fixed_tick_i(fixed_tick_i), .debug_halt_i(debug_halt_i),
    .counting_down_o(counting_down_o), .center_pwm_o(center_pwm_o), .irq_o(irq_o));

  // -------------------------------------------------------------
  // Clocks, tasks and the result watcher
  // -------------------------------------------------------------
  // The external source runs at one eighth of the bus, inside its limit.
  always #5 clk_i = ~clk_i;
  always begin
    repeat (4) @(posedge clk_i);
    ext_clk_i <= ~ext_clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 16);
    if (ack_o !== 1'b1) chk("ack", 32'h0, 32'h1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, int t);
    eq.push_back(e);
    mq.push_back(m);
    tq.push_back(t);
    bus(1'b0, a, 32'h0);
  endtask

  // Fixed-source ticks, one every other cycle, so counts are exact.
  task automatic ticks(input int n);
    repeat (n) begin
      fixed_tick_i <= 1'b1;
      @(posedge clk_i);
      fixed_tick_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  // Takes the oldest note when read data is acknowledged; free sources get a tolerance.
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && cyc_i && !we_i && eq.size() > 0) begin
      me = eq.pop_front();
      mm = mq.pop_front();
      mt = tq.pop_front();
      ms = dat_o & mm;
      if (mt > 0 && ms >= me - mt && ms <= me + mt) ms = me;
      chk("rdata", ms, me);
    end
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    chk("timeout", 32'h0, 32'h1);
    stop_test();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(SC, 32'h0, 32'hffffffff, 0);
    rd(CH, 32'h0, 32'hffffffff, 0);
    rd(MD, 32'h0, 32'hffff, 0);
    rd(8'h20, 32'h0, 32'hffffffff, 0);
    wr(CL, $random(seed));
    repeat (50) @(posedge clk_i);
    rd(CL, 32'h0, 32'hff, 0);
    $display("reset and stopped source done");
    for (int i = 0; i < 9; i++) begin
      sh = (i < 8) ? i : 3;
      wr(CL, $random(seed));
      wr(SC, (i < 8) ? (32'h08 | i) : 32'h18);
      repeat (1917) @(posedge clk_i);
      wr(SC, 32'h0);
      ex = 32'd1920 >> sh;
      rd(CH, ex >> 8, 32'hff, 0);
      rd(CL, ex & 32'hff, 32'hff, 2);
    end
    $display("prescale and sources done");
    wr(CL, $random(seed));
    wr(MD, 32'h10);
    wr(SC, 32'h48);
    repeat (40) @(posedge clk_i);
    chk("irq", irq_o, 32'h1);
    wr(SC, 32'hc0);
    rd(SC, 32'hc0, 32'hff, 0);
    wr(SC, 32'h00);
    rd(SC, 32'h00, 32'hff, 0);
    chk("irq", irq_o, 32'h0);
    rd(TCC_OFS_IRQ_STATUS, 32'h1, 32'h1, 0);
    wr(TCC_OFS_IRQ_MASK, 32'h1);
    chk("irq", irq_o, 32'h1);
    wr(TCC_OFS_IRQ_STATUS, 32'h1);
    chk("irq", irq_o, 32'h0);
    wr(TCC_OFS_IRQ_MASK, 32'h0);
    wr(SC, 32'h08);
    repeat (40) @(posedge clk_i);
    wr(SC, 32'h80);
    wr(SC, 32'h00);
    rd(SC, 32'h80, 32'h80, 0);
    wr(CL, $random(seed));
    wr(MD, 32'h1);
    wr(SC, 32'h08);
    rd(SC, 32'h80, 32'h80, 0);
    wr(SC, 32'h08);
    wr(SC, 32'h80);
    rd(SC, 32'h80, 32'h80, 0);
    wr(SC, 32'h00);
    wr(MD, 32'h10);
    wr(SC, 32'h28);
    for (int k = 0; k < 64 && counting_down_o !== 1'b1; k++) @(posedge clk_i);
    chk("down", counting_down_o, 32'h1);
    chk("center", center_pwm_o, 32'h1);
    wr(SC, 32'h00);
    wr(MD, 32'h0);
    $display("overflow and interrupt done");
    wr(SC, 32'h10);
    wr(CL, $random(seed));
    ticks(32'h1ff);
    rd(CH, 32'h01, 32'hff, 0);
    ticks(5);
    rd(CL, 32'hff, 32'hff, 0);
    rd(CL, 32'h04, 32'hff, 0);
    ticks(32'h100);
    rd(CH, 32'h02, 32'hff, 0);
    rd(CL, 32'h04, 32'hff, 0);
    debug_halt_i <= 1'b1;
    ticks(3);
    rd(CH, 32'h03, 32'hff, 0);
    rd(CH, 32'h03, 32'hff, 0);
    debug_halt_i <= 1'b0;
    ticks(32'h100);
    rd(CH, 32'h03, 32'hff, 0);
    rd(CL, 32'h04, 32'hff, 0);
    rd(CH, 32'h04, 32'hff, 0);
    debug_halt_i <= 1'b1;
    ticks(7);
    rd(CL, 32'h04, 32'hff, 0);
    rd(CL, 32'h04, 32'hff, 0);
    rd(CH, 32'h04, 32'hff, 0);
    debug_halt_i <= 1'b0;
    rd(CL, 32'h04, 32'hff, 0);
    debug_halt_i <= 1'b1;
    wr(SC, 32'h10);
    debug_halt_i <= 1'b0;
    ticks(32'h100);
    rd(CH, 32'h05, 32'hff, 0);
    rd(CL, 32'h04, 32'hff, 0);
    debug_halt_i <= 1'b1;
    wr(CH, $random(seed));
    rd(CL, 32'h00, 32'hff, 0);
    debug_halt_i <= 1'b0;
    $display("read buffer and halt done");
    stop_test();
  end
endmodule // tcc_core_tb
